// >>> core/hall_beam_mode_pulse_control.sv
`include "beam_ctrl_cfg.svh"

module hall_beam_mode_pulse_control
    import beam_ctrl_pkg::*;
#(
    parameter logic [7:0] BASE_HIGH = 8'h00,
    parameter int OSC_CYCLES = `OSC_CYCLES,
    parameter int SYNC_LOSS_CYCLES = `SYNC_LOSS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire vme_in_t vmeIn,
    input wire field_in_t fieldIn,
    output vme_out_t vmeOut,
    output logic [2:0] hallBeam,
    output logic [2:0] hallMod,
    output logic thermBeam,
    output logic thermMod
);
    // ****************************************************************
    // Timing constants
    // ****************************************************************
    localparam logic [11:0] TUNE_BEAM_T = 12'(`TUNE_BEAM_NS / `TICK_NS);
    localparam logic [11:0] MOD_START_T = 12'(`MOD_START_NS / `TICK_NS);
    localparam logic [11:0] MOD_BASE_T = 12'(`MOD_BASE_NS / `TICK_NS);
    localparam logic [11:0] THERM_OFF_T = 12'(`THERM_OFF_NS / `TICK_NS);
    localparam logic [11:0] VIEW_STEP_T = 12'(`VIEW_STEP_NS / `TICK_NS);
    localparam logic [7:0] VIEW_MAX_STEPS = 8'(`VIEW_MAX_NS / `VIEW_STEP_NS - 1);
    localparam logic [2:0] TICK_LAST = 3'(`TICK_CYCLES - 1);
    localparam logic [13:0] OSC_LAST = 14'(OSC_CYCLES - 1);
    localparam logic [21:0] SYNC_LOSS = 22'(SYNC_LOSS_CYCLES);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Address and data ride through the same two stages as the strobes,
    // so they are settled whenever the synchronised strobe is seen.
    vme_in_t vmeMeta_q;
    vme_in_t vmeSync_q;
    field_in_t fieldMeta_q;
    field_in_t fieldSync_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vmeMeta_q <= '{asN: 1'b1, ds0N: 1'b1, writeN: 1'b1, default: '0};
            vmeSync_q <= '{asN: 1'b1, ds0N: 1'b1, writeN: 1'b1, default: '0};
            fieldMeta_q <= '0;
            fieldSync_q <= '0;
        end else if (clkEn) begin
            vmeMeta_q <= vmeIn;
            vmeSync_q <= vmeMeta_q;
            fieldMeta_q <= fieldIn;
            fieldSync_q <= fieldMeta_q;
        end
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    bus_state_t busState_q;
    bus_state_t busState_d;
    wire logic strobe = !vmeSync_q.asN && !vmeSync_q.ds0N;
    wire logic [7:0] byteOfs = {vmeSync_q.addr[7:1], 1'b1};
    wire logic baseHit = vmeSync_q.addr[15:8] == BASE_HIGH;
    wire logic amOk = (vmeSync_q.am == `AM_SHORT_USER) || (vmeSync_q.am == `AM_SHORT_SUPER);
    wire logic mapped = byteOfs inside {`OFS_ACC_EN, `OFS_ACC_MODE, `OFS_HALL_A_EN,
        `OFS_HALL_A_MODE, `OFS_HALL_B_EN, `OFS_HALL_B_MODE, `OFS_HALL_C_EN,
        `OFS_HALL_C_MODE, `OFS_HARMONIC, `OFS_MOD_TRIM, `OFS_VIEW_WIDTH};
    wire logic take = (busState_q == BUS_IDLE) && strobe && baseHit && amOk && mapped;
    wire logic wrEn = take && !vmeSync_q.writeN;
    wire logic [7:0] wData = vmeSync_q.data;
    wire logic wrAccEn = wrEn && (byteOfs == `OFS_ACC_EN);
    wire logic wrAccMode = wrEn && (byteOfs == `OFS_ACC_MODE);
    wire logic wrHarm = wrEn && (byteOfs == `OFS_HARMONIC);
    wire logic wrTrim = wrEn && (byteOfs == `OFS_MOD_TRIM);
    wire logic wrView = wrEn && (byteOfs == `OFS_VIEW_WIDTH);
    wire logic [2:0] wrHallEn = {wrEn && (byteOfs == `OFS_HALL_C_EN),
        wrEn && (byteOfs == `OFS_HALL_B_EN), wrEn && (byteOfs == `OFS_HALL_A_EN)};
    wire logic [2:0] wrHallMode = {wrEn && (byteOfs == `OFS_HALL_C_MODE),
        wrEn && (byteOfs == `OFS_HALL_B_MODE), wrEn && (byteOfs == `OFS_HALL_A_MODE)};
    wire beam_mode_t wMode = beam_mode_t'(wData[`MODE_FIELD_LSB+:2]);

    always_comb begin
        busState_d = busState_q;
        unique case (busState_q)
            BUS_IDLE: begin
                if (take) begin
                    busState_d = BUS_ACK;
                end
            end
            BUS_ACK: begin
                if (!strobe) begin
                    busState_d = BUS_IDLE;
                end
            end
        endcase
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic accGo_q;
    beam_mode_t accMode_q;
    beam_mode_t accMode_d;
    logic testMode_q;
    logic [2:0] hallGo_q;
    beam_mode_t hallMode_q [3];
    beam_mode_t hallMode_d [3];
    logic [5:0] harmDiv_q;
    logic [3:0] modTrim_q;
    logic [7:0] viewWidth_q;

    // Hall codes and accelerator codes share one order, so the clamp is
    // a plain minimum; a hall can never sit above the accelerator.
    assign accMode_d = wrAccMode ? wMode : accMode_q;
    always_comb begin
        for (int h = 0; h < 3; h++) begin
            hallMode_d[h] = wrHallMode[h] ? wMode : hallMode_q[h];
            if (hallMode_d[h] > accMode_d) begin
                hallMode_d[h] = accMode_d;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busState_q <= BUS_IDLE;
            accGo_q <= 1'b0;
            accMode_q <= MODE_VIEWER;
            testMode_q <= 1'b0;
            hallGo_q <= 3'h0;
            hallMode_q <= '{MODE_VIEWER, MODE_VIEWER, MODE_VIEWER};
            harmDiv_q <= `HARMONIC_RESET;
            modTrim_q <= `MOD_TRIM_RESET;
            viewWidth_q <= `VIEW_WIDTH_RESET;
        end else if (clkEn) begin
            busState_q <= busState_d;
            accGo_q <= wrAccEn ? wData[0] : accGo_q;
            accMode_q <= accMode_d;
            testMode_q <= wrAccMode ? wData[`ACC_TEST_BIT] : testMode_q;
            for (int h = 0; h < 3; h++) begin
                hallGo_q[h] <= wrHallEn[h] ? wData[0] : hallGo_q[h];
            end
            hallMode_q <= hallMode_d;
            harmDiv_q <= wrHarm ? wData[5:0] : harmDiv_q;
            modTrim_q <= wrTrim ? wData[3:0] : modTrim_q;
            viewWidth_q <= wrView ? wData : viewWidth_q;
        end
    end

    // ****************************************************************
    // Fault latches
    // ****************************************************************
    // A latch only clears on a mode write while its fault is gone; a
    // fault still present in that cycle keeps it set.
    logic fsdLatch_q;
    logic pssALatch_q;
    logic pssBLatch_q;
    logic [2:0] hallFsdLatch_q;
    wire logic fsdIn = fieldSync_q.fastShutdownFault;
    wire logic pssAIn = fieldSync_q.safetyFaultA;
    wire logic pssBIn = fieldSync_q.safetyFaultB;
    wire logic [2:0] hallFsdIn = fieldSync_q.hallShutdownFault;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fsdLatch_q <= 1'b0;
            pssALatch_q <= 1'b0;
            pssBLatch_q <= 1'b0;
            hallFsdLatch_q <= 3'h0;
        end else if (clkEn) begin
            fsdLatch_q <= fsdIn || (fsdLatch_q && !wrAccMode);
            pssALatch_q <= pssAIn || (pssALatch_q && !wrAccMode);
            pssBLatch_q <= pssBIn || (pssBLatch_q && !wrAccMode);
            hallFsdLatch_q <= hallFsdIn | (hallFsdLatch_q & ~wrHallMode);
        end
    end

    // ****************************************************************
    // Line sync and harmonic trigger
    // ****************************************************************
    logic linePrev_q;
    logic [13:0] oscCnt_q;
    logic [5:0] harmCnt_q;
    logic [21:0] lossCnt_q;
    wire logic lineEdge = fieldSync_q.lineSync && !linePrev_q;
    wire logic oscTick = oscCnt_q == OSC_LAST;
    wire logic harmWrap = oscTick && (harmCnt_q == harmDiv_q - 6'h01);
    wire logic trigger = lineEdge || ((harmDiv_q != 6'h00) && harmWrap);
    wire logic syncPresent = lossCnt_q < SYNC_LOSS;

    // The oscillator restarts on every line edge, so it stays locked
    // to the line without an analogue loop.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            linePrev_q <= 1'b0;
            oscCnt_q <= 14'h0000;
            harmCnt_q <= 6'h00;
            lossCnt_q <= SYNC_LOSS;
        end else if (clkEn) begin
            linePrev_q <= fieldSync_q.lineSync;
            if (lineEdge || oscTick) begin
                oscCnt_q <= 14'h0000;
            end else begin
                oscCnt_q <= oscCnt_q + 14'h0001;
            end
            if (lineEdge || harmWrap) begin
                harmCnt_q <= 6'h00;
            end else if (oscTick) begin
                harmCnt_q <= harmCnt_q + 6'h01;
            end
            if (lineEdge) begin
                lossCnt_q <= 22'h000000;
            end else if (syncPresent) begin
                lossCnt_q <= lossCnt_q + 22'h000001;
            end
        end
    end

    // ****************************************************************
    // Pulse timebase
    // ****************************************************************
    // The timer rests at the end of the tune window, where every pulse
    // window is closed, until the first trigger arrives.
    logic [2:0] tickPre_q;
    logic [11:0] timer_q;
    wire logic tick = tickPre_q == TICK_LAST;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tickPre_q <= 3'h0;
            timer_q <= TUNE_BEAM_T;
        end else if (clkEn) begin
            if (trigger || tick) begin
                tickPre_q <= 3'h0;
            end else begin
                tickPre_q <= tickPre_q + 3'h1;
            end
            if (trigger) begin
                timer_q <= 12'h000;
            end else if (tick && (timer_q < TUNE_BEAM_T)) begin
                timer_q <= timer_q + 12'h001;
            end
        end
    end

    // ****************************************************************
    // Waveform windows
    // ****************************************************************
    wire logic [7:0] viewSteps = (viewWidth_q > VIEW_MAX_STEPS) ? VIEW_MAX_STEPS : viewWidth_q;
    wire logic [11:0] viewEnd = 12'((12'(viewSteps) + 12'h001) * VIEW_STEP_T);
    logic [11:0] viewEnd_q;

    // The width is taken at the trigger, so a write in mid-period can
    // neither stretch nor reopen a pulse that is off the line phase.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            viewEnd_q <= 12'h000;
        end else if (clkEn && trigger) begin
            viewEnd_q <= viewEnd;
        end
    end

    wire logic viewOn = timer_q < viewEnd_q;
    wire logic tuneBeam = timer_q < TUNE_BEAM_T;
    wire logic [11:0] modEnd = MOD_START_T + MOD_BASE_T + 12'(modTrim_q);
    wire logic tuneMod = (timer_q >= MOD_START_T) && (timer_q < modEnd);
    wire logic thermTune = (timer_q < MOD_START_T) ||
        ((timer_q >= MOD_START_T + THERM_OFF_T) && tuneBeam);

    // ****************************************************************
    // Gating
    // ****************************************************************
    wire logic hvOff = fieldSync_q.gunVoltageOff;
    wire logic valveClosed = fieldSync_q.valveClosed;
    wire logic polEnabled = !valveClosed || testMode_q;
    wire logic thermEnabled = valveClosed || testMode_q;
    wire logic polTest = valveClosed && testMode_q;
    wire logic globalFault = (fsdLatch_q || pssALatch_q || pssBLatch_q) && !hvOff;
    wire logic anyFault = (globalFault || (|hallFsdLatch_q)) && !hvOff;
    wire logic [2:0] hallFault = hallFsdLatch_q & {3{!polTest && !hvOff}};
    wire logic thermActive = accGo_q && thermEnabled && !anyFault;

    logic [2:0] hallActive;
    logic [2:0] hallBeam_d;
    logic [2:0] hallMod_d;
    logic thermBeam_d;
    logic thermMod_d;

    always_comb begin
        for (int h = 0; h < 3; h++) begin
            hallActive[h] = accGo_q && hallGo_q[h] && polEnabled && !globalFault &&
                !hallFault[h];
            hallBeam_d[h] = 1'b0;
            hallMod_d[h] = 1'b0;
            if (hallActive[h]) begin
                unique case (hallMode_q[h])
                    MODE_VIEWER: begin
                        hallBeam_d[h] = viewOn;
                    end
                    MODE_TUNE: begin
                        hallBeam_d[h] = tuneBeam;
                        hallMod_d[h] = tuneMod;
                    end
                    MODE_CONTINUOUS: begin
                        hallBeam_d[h] = 1'b1;
                    end
                    MODE_PASS: begin
                        hallBeam_d[h] = fieldSync_q.pulserBeam;
                        hallMod_d[h] = fieldSync_q.pulserMod;
                    end
                endcase
            end
        end
        thermBeam_d = 1'b0;
        thermMod_d = 1'b0;
        if (thermActive) begin
            unique case (accMode_q)
                MODE_VIEWER: begin
                    thermBeam_d = viewOn;
                end
                MODE_TUNE: begin
                    thermBeam_d = thermTune;
                end
                MODE_CONTINUOUS: begin
                    thermBeam_d = 1'b1;
                end
                MODE_PASS: begin
                    thermBeam_d = fieldSync_q.pulserBeam;
                    thermMod_d = fieldSync_q.pulserMod;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire logic accActive = accGo_q && !globalFault;
    logic [7:0] rData;

    always_comb begin
        rData = 8'h00;
        unique case (byteOfs)
            `OFS_ACC_EN: rData = {7'h00, accGo_q};
            `OFS_ACC_MODE: rData = {accActive, syncPresent, accMode_q, testMode_q,
                pssALatch_q, pssBLatch_q, fsdLatch_q};
            `OFS_HALL_A_MODE: rData = {hallActive[0], 1'b0, hallMode_q[0], 3'h0,
                hallFsdLatch_q[0]};
            `OFS_HALL_B_MODE: rData = {hallActive[1], 1'b0, hallMode_q[1], 3'h0,
                hallFsdLatch_q[1]};
            `OFS_HALL_C_MODE: rData = {hallActive[2], 1'b0, hallMode_q[2], 3'h0,
                hallFsdLatch_q[2]};
            `OFS_HARMONIC: rData = {2'h0, harmDiv_q};
            `OFS_MOD_TRIM: rData = {4'h0, modTrim_q};
            `OFS_VIEW_WIDTH: rData = viewWidth_q;
            default: rData = 8'h00;
        endcase
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // Unmapped or foreign accesses get no acknowledge; the bus timer
    // of the host then ends the cycle.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vmeOut <= '{data: 8'h00, dataOe: 1'b0, dtackN: 1'b1, dtackOe: 1'b0};
            hallBeam <= 3'h0;
            hallMod <= 3'h0;
            thermBeam <= 1'b0;
            thermMod <= 1'b0;
        end else if (clkEn) begin
            if (take) begin
                vmeOut.data <= rData;
                vmeOut.dataOe <= vmeSync_q.writeN;
                vmeOut.dtackN <= 1'b0;
                vmeOut.dtackOe <= 1'b1;
            end else if (busState_q == BUS_ACK && !strobe) begin
                vmeOut.dataOe <= 1'b0;
                vmeOut.dtackN <= 1'b1;
                vmeOut.dtackOe <= 1'b0;
            end
            hallBeam <= hallBeam_d;
            hallMod <= hallMod_d;
            thermBeam <= thermBeam_d;
            thermMod <= thermMod_d;
        end
    end
endmodule

// >>> core/beam_ctrl_cfg.svh
`ifndef BEAM_CTRL_CFG_SVH
`define BEAM_CTRL_CFG_SVH
`define OFS_ACC_EN 8'h01
`define OFS_ACC_MODE 8'h03
`define OFS_HALL_A_EN 8'h05
`define OFS_HALL_A_MODE 8'h07
`define OFS_HALL_B_EN 8'h09
`define OFS_HALL_B_MODE 8'h0B
`define OFS_HALL_C_EN 8'h0D
`define OFS_HALL_C_MODE 8'h0F
`define OFS_HARMONIC 8'h11
`define OFS_MOD_TRIM 8'h13
`define OFS_VIEW_WIDTH 8'h15
`define AM_SHORT_USER 6'h29
`define AM_SHORT_SUPER 6'h2D
`define MODE_FIELD_LSB 4
`define STATUS_ACTIVE_BIT 7
`define ACC_SYNC_BIT 6
`define ACC_TEST_BIT 3
`define MOD_TRIM_RESET 4'h8
`define VIEW_WIDTH_RESET 8'h00
`define HARMONIC_RESET 6'h00
`define CLK_HZ 40000000
`define CLK_PERIOD_NS 25
`define TICK_NS 125
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define OSC_HZ 4320
`define OSC_CYCLES (`CLK_HZ / `OSC_HZ)
`define SYNC_LOSS_CYCLES (`CLK_HZ / 30)
`define TUNE_BEAM_NS 354000
`define MOD_START_NS 250000
`define MOD_BASE_NS 98500
`define THERM_OFF_NS 100000
`define VIEW_STEP_NS 250
`define VIEW_MAX_NS 10000
`endif

// >>> core/beam_ctrl_pkg.sv
package beam_ctrl_pkg;
    typedef enum logic [1:0] {
        MODE_VIEWER = 2'b00,
        MODE_TUNE = 2'b01,
        MODE_CONTINUOUS = 2'b10,
        MODE_PASS = 2'b11
    } beam_mode_t;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;
    typedef struct packed {
        logic asN;
        logic ds0N;
        logic writeN;
        logic [5:0] am;
        logic [15:1] addr;
        logic [7:0] data;
    } vme_in_t;
    typedef struct packed {
        logic [7:0] data;
        logic dataOe;
        logic dtackN;
        logic dtackOe;
    } vme_out_t;
    typedef struct packed {
        logic lineSync;
        logic pulserBeam;
        logic pulserMod;
        logic fastShutdownFault;
        logic [2:0] hallShutdownFault;
        logic safetyFaultA;
        logic safetyFaultB;
        logic gunVoltageOff;
        logic valveClosed;
    } field_in_t;
endpackage

// >>> sim/beam_assertions.sv
// ****************************************
// Bus and fault checks
// ****************************************
module beam_assertions
    import beam_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire vme_in_t vmeIn,
    input wire field_in_t fieldIn,
    input wire vme_out_t vmeOut,
    input wire logic [2:0] hallBeam,
    input wire logic [2:0] hallMod,
    input wire logic thermBeam,
    input wire logic thermMod
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire logic strobe = !vmeIn.asN && !vmeIn.ds0N && clkEn;
    wire logic mapped = vmeIn.addr[15:8] == 8'h00 && vmeIn.addr[7:1] <= 7'h0A
        && (vmeIn.am == 6'h29 || vmeIn.am == 6'h2D);
    wire logic allOff = hallBeam == 3'h0 && hallMod == 3'h0 && !thermBeam && !thermMod;
    wire logic hallFaultA = fieldIn.hallShutdownFault[0] && !fieldIn.valveClosed;
    // Fault latches hold, so the two extra cycles cannot hide a missed stop.
    sequence faultHeld(f);
        (f && !fieldIn.gunVoltageOff && clkEn) [*5];
    endsequence
    sequence mappedHeld;
        (strobe && mapped) [*3];
    endsequence
    a_ack_after_take: assert property (mappedHeld |=> !vmeOut.dtackN && vmeOut.dtackOe)
        else $error("Mapped access not acknowledged.");
    a_unmapped_silent: assert property ((strobe && !mapped) [*6] |-> !vmeOut.dtackOe)
        else $error("Unmapped access acknowledged.");
    a_release_ack_off: assert property (vmeIn.ds0N [*5] |->
        vmeOut.dtackN && !vmeOut.dtackOe && !vmeOut.dataOe) else $error("Ack held too long.");
    a_data_with_ack: assert property ($rose(vmeOut.dataOe) |-> $rose(vmeOut.dtackOe))
        else $error("Read data without ack.");
    a_fsd_stops_all: assert property (faultHeld(fieldIn.fastShutdownFault) |-> ##2 allOff)
        else $error("Accelerator fault left outputs on.");
    a_safety_stops_all: assert property
        (faultHeld(fieldIn.safetyFaultA || fieldIn.safetyFaultB) |-> ##2 allOff)
        else $error("Safety fault left outputs on.");
    a_hall_fault_own: assert property
        (faultHeld(hallFaultA) |-> ##2 !hallBeam[0] && !hallMod[0])
        else $error("Hall fault left hall outputs on.");
    a_therm_fault_stop: assert property
        (faultHeld(|fieldIn.hallShutdownFault) |-> ##2 !thermBeam && !thermMod)
        else $error("Hall fault left gun outputs on.");
endmodule

bind hall_beam_mode_pulse_control beam_assertions chk (.sys_clk, .nrst, .clkEn, .vmeIn,
    .fieldIn, .vmeOut, .hallBeam, .hallMod, .thermBeam, .thermMod);

// >>> sim/vme_host.sv
// ****************************************
// Bus host model
// ****************************************
module vme_host
    import beam_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire vme_out_t vmeOut,
    output vme_in_t vmeIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial vmeIn = '{1'b1, 1'b1, 1'b1, 6'h29, 15'h7FFF, 8'hA5};
    // A refused access never acks, so the wait gives up after 12 edges.
    task automatic access(input logic wr, input logic [7:0] ofs, input logic [7:0] wd,
        output logic [7:0] rd, output logic ok);
        int n = 0;
        @(posedge sys_clk);
        #1;
        vmeIn.am = $urandom % 2 ? 6'h2D : 6'h29;
        vmeIn.addr = {8'h00, ofs[7:1]};
        vmeIn.writeN = !wr;
        vmeIn.data = wd;
        {vmeIn.asN, vmeIn.ds0N} = 2'b00;
        while (!(vmeOut.dtackOe && !vmeOut.dtackN) && n < 12) begin
            @(posedge sys_clk);
            n++;
        end
        ok = n < 12;
        rd = vmeOut.data;
        #1;
        {vmeIn.asN, vmeIn.ds0N} = 2'b11;
        vmeIn.data = ~wd;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask
endmodule

// >>> sim/testbench.sv
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
// ****************************************
// Bench top
// ****************************************
module testbench
    import beam_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    field_in_t fieldIn = '0;
    vme_in_t vmeIn;
    vme_out_t vmeOut;
    logic [2:0] hallBeam;
    logic [2:0] hallMod;
    logic thermBeam;
    logic thermMod;
    logic [7:0] rd;
    logic ok;
    int errors = 0;
    int cmp_count = 0;
    int n, s, m, th, trim;
    logic [7:0] tab[8][3] = '{'{8'h01, 8'h01, 8'h00}, '{8'h03, 8'h38, 8'h00},
        '{8'h07, 8'hB1, 8'h00}, '{8'h0B, 8'hB1, 8'h00}, '{8'h0F, 8'hB1, 8'h00},
        '{8'h11, 8'h3F, 8'h00}, '{8'h13, 8'h0F, 8'h08}, '{8'h15, 8'hFF, 8'h00}};
    logic [7:0] hv[8] = '{8'h24, 8'h18, 8'h12, 8'h0C, 8'h09, 8'h08, 8'h06, 8'h00};
    int wl[3] = '{0, 3, 60};
    always #12.5 sys_clk = ~sys_clk;
    // Short oscillator and sync-loss counts keep the run brief.
    hall_beam_mode_pulse_control #(.OSC_CYCLES(20), .SYNC_LOSS_CYCLES(40000)) uut (.sys_clk,
        .nrst, .clkEn, .vmeIn, .fieldIn, .vmeOut, .hallBeam, .hallMod, .thermBeam, .thermMod);
    vme_host host (.sys_clk, .vmeOut, .vmeIn);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, rd, ok);
        `CHK(ok, 1'b1)
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] k, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, rd, ok);
        `CHK({ok, rd & k}, {1'b1, e})
    endtask
    task automatic waitc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic meas;
        int t = 0;
        // A window opened before this call must run out, or it would be counted.
        while (hallBeam[0] && t < 20000) begin
            waitc(1);
            t++;
        end
        t = 0;
        fieldIn.lineSync = 1'b1;
        {n, s, m, th} = '0;
        while (!hallBeam[0] && t < 20000) begin
            waitc(1);
            t++;
        end
        while (hallBeam[0] && n < 20000) begin
            s = m ? s : n;
            m += hallMod[0];
            th += thermBeam;
            waitc(1);
            n++;
        end
        fieldIn.lineSync = 1'b0;
    endtask
    task automatic end_of_test;
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #2000000;
        errors++;
        end_of_test;
    end
    initial begin
        void'($urandom(65));
        repeat (16) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        foreach (tab[i]) rdchk(tab[i][0], tab[i][1], tab[i][2]);
        foreach (hv[i]) begin
            wr(8'h11, hv[i]);
            rdchk(8'h11, 8'h3F, hv[i]);
        end
        trim = $urandom % 16;
        wr(8'h13, 8'(trim));
        rdchk(8'h13, 8'h0F, 8'(trim));
        for (int a = 0; a < 4; a++) begin
            for (int h = 0; h < 4; h++) begin
                wr(8'h03, 8'(a * 16));
                wr(8'h07, 8'(h * 16));
                rdchk(8'h07, 8'h30, 8'((a < h ? a : h) * 16));
            end
        end
        wr(8'h0B, 8'h30);
        for (int a = 3; a >= 0; a--) begin
            wr(8'h03, 8'(a * 16));
            rdchk(8'h0B, 8'h30, 8'(a * 16));
        end
        host.access(1'b0, 8'h17, 8'h00, rd, ok);
        `CHK(ok, 1'b0)
        wr(8'h03, 8'h30);
        wr(8'h01, 8'h01);
        wr(8'h05, 8'h01);
        rdchk(8'h05, 8'hFF, 8'h00);
        wr(8'h07, 8'h20);
        rdchk(8'h07, 8'hB1, 8'hA0);
        `CHK({hallBeam[0], hallMod[0]}, 2'b10)
        wr(8'h05, 8'h00);
        rdchk(8'h07, 8'h80, 8'h00);
        `CHK(hallBeam[0], 1'b0)
        wr(8'h05, 8'h01);
        fieldIn.hallShutdownFault = 3'h1;
        waitc(8);
        rdchk(8'h07, 8'h81, 8'h01);
        fieldIn.hallShutdownFault = 3'h0;
        rdchk(8'h07, 8'h01, 8'h01);
        wr(8'h07, 8'h20);
        rdchk(8'h07, 8'h81, 8'h80);
        fieldIn.gunVoltageOff = 1'b1;
        waitc(4);
        fieldIn.safetyFaultA = 1'b1;
        fieldIn.fastShutdownFault = 1'b1;
        waitc(8);
        `CHK(hallBeam[0], 1'b1)
        fieldIn.gunVoltageOff = 1'b0;
        waitc(8);
        `CHK(hallBeam[0], 1'b0)
        fieldIn = '0;
        wr(8'h03, 8'h30);
        rdchk(8'h03, 8'h07, 8'h00);
        `CHK(hallBeam[0], 1'b1)
        wr(8'h03, 8'h38);
        wr(8'h07, 8'h30);
        repeat (8) begin
            fieldIn.pulserBeam = 1'($urandom);
            fieldIn.pulserMod = 1'($urandom);
            waitc(6);
            `CHK({hallBeam[0], hallMod[0]}, {fieldIn.pulserBeam, fieldIn.pulserMod})
            `CHK({thermBeam, thermMod}, {fieldIn.pulserBeam, fieldIn.pulserMod})
        end
        clkEn = 1'b0;
        fieldIn.pulserBeam = !hallBeam[0];
        waitc(6);
        `CHK(hallBeam[0], !fieldIn.pulserBeam)
        clkEn = 1'b1;
        fieldIn.pulserBeam = 1'b1;
        fieldIn.valveClosed = 1'b1;
        fieldIn.hallShutdownFault = 3'h1;
        waitc(6);
        `CHK(hallBeam[0], 1'b1)
        `CHK({thermBeam, thermMod}, 2'b00)
        fieldIn = '0;
        wr(8'h07, 8'h00);
        foreach (wl[i]) begin
            wr(8'h15, 8'(wl[i]));
            meas;
            `CHK(n, ((wl[i] < 39 ? wl[i] : 39) + 1) * 10)
        end
        wr(8'h03, 8'h18);
        wr(8'h07, 8'h10);
        meas;
        `CHK(n, 14160)
        `CHK(s, 10000)
        `CHK(m, (788 + trim) * 5)
        `CHK(th, (2000 + 32) * 5)
        end_of_test;
    end
endmodule
